// [rtl/hrc_ctrl.sv]
// Reset, self-test and configuration handshake controller of the board
//
// Summary of operation
// - Bus init or reset-port write resets board.
// - Indicator stays lit while self test runs.
// - Test pass sets pass bit, indicator blinks.
// - No pass in 3 s: repeat error code.
// - Strap picks network boot or host configuration.
// - Status bit 3 high until byte consumed.
// - Status bit 0 zero until test passes.
// - Sequence opens with prefix FF FF 00 00.
// - Address bytes follow, least significant first.
// - Eighth byte starts fetch; bad address shows code.
// - Completion code written, never FF; zero success.
// - Configuration normally completes within 3 seconds.
// - Other reply fields only written on success.
// - Reserved first word must equal one.
// - Reply holds four ASCII version digits at 2.
// - Codes A4, A5, A7 for mode, pattern, format.
// - Codes A8, A9, AA for block, processes, mailboxes.
// - Codes AB, AC, AD for slots, hosts, queues.
// - Codes AE no memory, AF netboot failure.
// - Failed configuration shows code on indicator.
// - Format at 8, context at 10, mode 13.
// - Operation mode 0, 1, 2; others rejected.
`timescale 1ns/1ps
`default_nettype none

module hrc_ctrl #(
	parameter int unsigned SELFTEST_TO = hrc_pkg::SELFTEST_TO_CYC, // Self-test budget
	parameter int unsigned CFG_TO = hrc_pkg::CFG_TO_CYC, // Fetch budget
	parameter int unsigned BLINK = hrc_pkg::BLINK_CYC, // Indicator step
	parameter logic [7:0] VER_X = 8'h31, // Firmware major digit, arbitrary
	parameter logic [7:0] VER_Y = 8'h30, // Firmware minor digit, arbitrary
	parameter logic [7:0] VER_A = 8'h31, // Board major digit, arbitrary
	parameter logic [7:0] VER_B = 8'h30, // Board minor digit, arbitrary
	parameter logic [7:0] CTX_VAL = 8'h01 // Context value, arbitrary
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Host-side port strobes
	input wire logic bus_init,
	input wire logic rst_port_wr,
	input wire logic cmd_wr,
	input wire logic [7:0] cmd_wdata,
	output logic [7:0] status_byte,
	// Board-level inputs
	input wire logic strap_netboot,
	input wire logic selftest_done,
	input wire logic selftest_pass,
	input wire logic loop_fail,
	input wire logic board_mem_low,
	// Network bootstrap engine
	output logic netboot_start,
	input wire logic netboot_done,
	input wire logic netboot_ok,
	// Shared memory master port
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [7:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic mem_err,
	input wire logic [7:0] mem_rdata,
	// Indicator and state
	output logic status_led,
	output logic selftest_run,
	output logic cfg_done,
	output logic [7:0] cfg_code
);
	import hrc_pkg::*;

	// Whole controller state in one record
	typedef struct packed {
		hrc_state_e state; // Controller state
		logic pass; // Self test passed
		logic ready; // Command byte waiting
		logic [7:0] cmd_byte; // Latched command byte
		logic [7:0] status; // Status byte as read
		logic [2:0] seq; // Position in address sequence
		logic [31:0] addr; // Message base address
		logic [31:0] tmr; // Budget timer
		logic [31:0] blink_cnt; // Indicator step timer
		logic [3:0] slot; // Code display slot
		logic led; // Indicator
		logic [7:0] code; // Completion or error code
		logic [6:0] idx; // Fetch, check and reply index
		logic chk_vld; // Buffer data valid for chk_off
		logic [6:0] chk_off; // Offset of buffered byte
		logic [7:0] aux; // First reserved byte
		logic [7:0] mode; // Operation mode seen
		logic from_cfg; // Netboot asked by message
		logic mem_req;
		logic mem_we;
		logic [31:0] mem_addr;
		logic [7:0] mem_wdata;
		logic buf_we;
		logic [6:0] buf_waddr;
		logic [7:0] buf_wdata;
		logic netboot_start;
		logic selftest_run;
		logic cfg_done;
	} hrc_ctrl_s;

	// Value taken on any kind of reset
	localparam hrc_ctrl_s RST_VAL = '{state: S_SELFTEST, led: 1'b1, selftest_run: 1'b1,
		code: CC_PEND, default: '0};

	hrc_ctrl_s ctl_ff; // Registered state
	hrc_ctrl_s nxt_ctl; // Next state
	logic [7:0] buf_rdata; // Buffered message byte

	// Field check of one message byte, first error found wins
	function automatic logic [7:0] chk_byte(input logic [6:0] off, input logic [7:0] b,
		input logic [7:0] md, input logic [7:0] b0);
		logic keep;
		logic lim_bad;
		keep = (b == KEEP_VAL);
		lim_bad = (b == 8'h00) || (b > CNT_MAX);
		chk_byte = CC_OK;
		if (off == OFF_RSV0 + 7'h01) begin
			// Either byte order of the word one
			if (!((b0 == RSV0_VAL && b == 8'h00) || (b0 == 8'h00 && b == RSV0_VAL)))
				chk_byte = CC_FORMAT;
		end else if (off == OFF_MODE) begin
			if (b > MODE_NET)
				chk_byte = CC_MODE;
		end else if (off == OFF_FMT || off == OFF_FMT + 7'h01) begin
			if ((b & FMT_RSV_MASK) != 8'h00)
				chk_byte = CC_FORMAT;
		end else if (off >= OFF_CTX && off < OFF_AMODE) begin
			if (b != 8'h00)
				chk_byte = CC_FORMAT;
		end else if (off == OFF_AMODE) begin
			if ((b & AMODE_RSV_MASK) != 8'h00)
				chk_byte = CC_FORMAT;
		end else if (off == OFF_RSV14 || off == OFF_MAPSZ) begin
			if (b != 8'h00)
				chk_byte = CC_FORMAT;
		end else if (off >= OFF_TP && off < OFF_TP + 7'h04) begin
			if (b != TP_BYTES[{off[1:0], 3'b000} +: 8])
				chk_byte = CC_PATTERN;
		end else if (off >= OFF_TP_RSV && off < OFF_MOVE) begin
			if (b != 8'h00)
				chk_byte = CC_PATTERN;
		end else if (off >= OFF_MOVE && off < OFF_NPROC) begin
			if (md == MODE_LINK && !keep)
				chk_byte = CC_MOVE;
		end else if (off == OFF_NPROC || off == OFF_NMBOX) begin
			if (!keep && (md == MODE_LINK || lim_bad))
				chk_byte = (off == OFF_NPROC) ? CC_NPROC : CC_NMBOX;
		end else if (off == OFF_NSLOT) begin
			if (!keep && b > SLOT_MAX)
				chk_byte = CC_NSLOT;
		end else if (off == OFF_NHOST) begin
			if (!keep && (b == 8'h00 || b > HOST_MAX))
				chk_byte = CC_NHOST;
		end else if (off == OFF_H2D_IRQ || off == OFF_D2H_IRQ) begin
			if (b > IRQ_TYPE_MAX)
				chk_byte = CC_QUEUE;
		end
	endfunction

	// Reply step to message offset: version digits, context, code last
	function automatic logic [6:0] reply_off(input logic [2:0] step);
		case (step)
			3'h4: reply_off = OFF_CTX_MID;
			3'h5: reply_off = OFF_CODE;
			default: reply_off = OFF_VER + {4'h0, step};
		endcase
	endfunction

	// Next-state logic
	always_comb begin
		logic tick;
		logic [7:0] res;
		logic [7:0] b;
		tick = 1'b0;
		res = CC_OK;
		b = ctl_ff.cmd_byte;
		nxt_ctl = ctl_ff;
		nxt_ctl.netboot_start = 1'b0;
		nxt_ctl.buf_we = 1'b0;

		// Indicator step timer
		if (ctl_ff.blink_cnt >= BLINK - 1) begin
			nxt_ctl.blink_cnt = '0;
			tick = 1'b1;
		end else begin
			nxt_ctl.blink_cnt = ctl_ff.blink_cnt + 32'h1;
		end

		// Command byte: latch when free, consume the next cycle
		if (ctl_ff.ready) begin
			nxt_ctl.ready = 1'b0;
		end else if (cmd_wr) begin
			nxt_ctl.ready = 1'b1;
			nxt_ctl.cmd_byte = cmd_wdata;
		end
		// Writes while ready is high fall through untouched

		case (ctl_ff.state)
			S_SELFTEST: begin
				nxt_ctl.led = 1'b1;
				nxt_ctl.tmr = ctl_ff.tmr + 32'h1;
				if (selftest_done && selftest_pass) begin
					nxt_ctl.pass = 1'b1;
					nxt_ctl.selftest_run = 1'b0;
					nxt_ctl.tmr = '0;
					if (strap_netboot) begin
						nxt_ctl.state = S_NETBOOT;
						nxt_ctl.netboot_start = 1'b1;
					end else begin
						nxt_ctl.state = S_WAIT;
					end
				end else if (selftest_done || ctl_ff.tmr >= SELFTEST_TO - 1) begin
					// Failure or no verdict in budget: show code until reset
					nxt_ctl.selftest_run = 1'b0;
					nxt_ctl.code = CC_SELFTEST;
					nxt_ctl.slot = '0;
					nxt_ctl.state = S_ERR;
				end
			end
			S_NETBOOT: begin
				if (tick)
					nxt_ctl.led = ~ctl_ff.led;
				if (netboot_done) begin
					nxt_ctl.code = netboot_ok ? CC_OK : CC_NETBOOT;
					if (ctl_ff.from_cfg) begin
						nxt_ctl.state = S_REPLY;
						nxt_ctl.idx = netboot_ok ? 7'h00 : {4'h0, REPLY_LAST};
					end else begin
						nxt_ctl.state = netboot_ok ? S_RUN : S_ERR;
						nxt_ctl.cfg_done = netboot_ok;
						nxt_ctl.slot = '0;
					end
				end
			end
			S_WAIT: begin
				if (tick)
					nxt_ctl.led = ~ctl_ff.led;
				if (ctl_ff.ready) begin
					if (ctl_ff.seq <= SEQ_PFX_LAST) begin
						if (b == SEQ_PREFIX[{ctl_ff.seq[1:0], 3'b000} +: 8]) begin
							nxt_ctl.seq = ctl_ff.seq + 3'h1;
						end else begin
							// Mismatch drops the partial sequence; FF may restart it
							nxt_ctl.seq = (b == SEQ_PREFIX[7:0]) ? 3'h1 : 3'h0;
						end
					end else begin
						nxt_ctl.addr[{ctl_ff.seq[1:0], 3'b000} +: 8] = b;
						nxt_ctl.seq = ctl_ff.seq + 3'h1;
						if (ctl_ff.seq == SEQ_LAST) begin
							nxt_ctl.seq = '0;
							nxt_ctl.idx = '0;
							nxt_ctl.tmr = '0;
							if (nxt_ctl.addr[0]) begin
								// Odd base cannot be a valid message
								nxt_ctl.code = CC_FORMAT;
								nxt_ctl.slot = '0;
								nxt_ctl.state = S_ERR;
							end else begin
								nxt_ctl.state = S_FETCH;
							end
						end
					end
				end
			end
			S_FETCH: begin
				nxt_ctl.tmr = ctl_ff.tmr + 32'h1;
				nxt_ctl.mem_req = 1'b1;
				nxt_ctl.mem_we = 1'b0;
				nxt_ctl.mem_addr = ctl_ff.addr + {25'h0, ctl_ff.idx};
				if (ctl_ff.mem_req && mem_ack) begin
					nxt_ctl.mem_req = 1'b0;
					if (mem_err) begin
						nxt_ctl.code = CC_FORMAT;
						nxt_ctl.slot = '0;
						nxt_ctl.state = S_ERR;
					end else begin
						nxt_ctl.buf_we = 1'b1;
						nxt_ctl.buf_waddr = ctl_ff.idx;
						nxt_ctl.buf_wdata = mem_rdata;
						nxt_ctl.idx = ctl_ff.idx + 7'h01;
						if (ctl_ff.idx == 7'(MSG_LEN - 1)) begin
							nxt_ctl.idx = '0;
							nxt_ctl.chk_vld = 1'b0;
							nxt_ctl.state = S_CHECK;
						end
					end
				end else if (ctl_ff.tmr >= CFG_TO - 1) begin
					// Address leads nowhere: give up and show it
					nxt_ctl.mem_req = 1'b0;
					nxt_ctl.code = CC_FORMAT;
					nxt_ctl.slot = '0;
					nxt_ctl.state = S_ERR;
				end
			end
			S_CHECK: begin
				// Buffer read runs one byte ahead of the check
				nxt_ctl.chk_off = ctl_ff.idx;
				nxt_ctl.chk_vld = (ctl_ff.idx < 7'(MSG_LEN));
				if (ctl_ff.idx < 7'(MSG_LEN))
					nxt_ctl.idx = ctl_ff.idx + 7'h01;
				if (ctl_ff.chk_vld) begin
					res = chk_byte(ctl_ff.chk_off, buf_rdata, ctl_ff.mode, ctl_ff.aux);
					if (ctl_ff.chk_off == OFF_RSV0)
						nxt_ctl.aux = buf_rdata;
					if (ctl_ff.chk_off == OFF_MODE)
						nxt_ctl.mode = buf_rdata;
					if (ctl_ff.code == CC_PEND && res != CC_OK)
						nxt_ctl.code = res;
					if (ctl_ff.chk_off == 7'(MSG_LEN - 1)) begin
						if (nxt_ctl.code == CC_PEND && ctl_ff.mode != MODE_LINK && board_mem_low)
							nxt_ctl.code = CC_NOMEM;
						if (nxt_ctl.code == CC_PEND && ctl_ff.mode == MODE_NET) begin
							nxt_ctl.from_cfg = 1'b1;
							nxt_ctl.netboot_start = 1'b1;
							nxt_ctl.state = S_NETBOOT;
						end else begin
							if (nxt_ctl.code == CC_PEND)
								nxt_ctl.code = CC_OK;
							// Failure writes only the code
							nxt_ctl.idx = (nxt_ctl.code == CC_OK) ? 7'h00 : {4'h0, REPLY_LAST};
							nxt_ctl.state = S_REPLY;
						end
					end
				end
			end
			S_REPLY: begin
				nxt_ctl.mem_req = 1'b1;
				nxt_ctl.mem_we = 1'b1;
				nxt_ctl.mem_addr = ctl_ff.addr + {25'h0, reply_off(ctl_ff.idx[2:0])};
				case (ctl_ff.idx[2:0])
					3'h0: nxt_ctl.mem_wdata = VER_X;
					3'h1: nxt_ctl.mem_wdata = VER_Y;
					3'h2: nxt_ctl.mem_wdata = VER_A;
					3'h3: nxt_ctl.mem_wdata = VER_B;
					3'h4: nxt_ctl.mem_wdata = CTX_VAL;
					default: nxt_ctl.mem_wdata = ctl_ff.code;
				endcase
				if (ctl_ff.mem_req && mem_ack) begin
					nxt_ctl.mem_req = 1'b0;
					nxt_ctl.mem_we = 1'b0;
					nxt_ctl.idx = ctl_ff.idx + 7'h01;
					if (ctl_ff.idx[2:0] == REPLY_LAST) begin
						nxt_ctl.slot = '0;
						nxt_ctl.cfg_done = (ctl_ff.code == CC_OK);
						nxt_ctl.state = (ctl_ff.code == CC_OK) ? S_RUN : S_ERR;
					end
				end
			end
			S_RUN: begin
				if (tick)
					nxt_ctl.led = ~ctl_ff.led;
			end
			S_ERR: begin
				// Code shown MSB first in slots 0..7, dark in 8..15, repeated
				if (tick)
					nxt_ctl.slot = ctl_ff.slot + 4'h1;
				nxt_ctl.led = !ctl_ff.slot[3] && ctl_ff.code[~ctl_ff.slot[2:0]];
			end
			default: begin
				nxt_ctl = RST_VAL;
			end
		endcase

		// Either reset source restarts the board from scratch
		if (bus_init || rst_port_wr)
			nxt_ctl = RST_VAL;

		// Status byte mirrors the next flags so reads see them at once
		nxt_ctl.status = '0;
		nxt_ctl.status[ST_PASS_BIT] = nxt_ctl.pass;
		nxt_ctl.status[ST_READY_BIT] = nxt_ctl.ready;
		nxt_ctl.status[ST_LOOP_BIT] = loop_fail;
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_ff <= RST_VAL;
		end else begin
			ctl_ff <= nxt_ctl;
		end
	end

	// Message buffer, read address from the index register
	hrc_msg_buf u_buf (
		.clk(clk),
		.rst_n(rst_n),
		.we(ctl_ff.buf_we),
		.waddr(ctl_ff.buf_waddr),
		.wdata(ctl_ff.buf_wdata),
		.raddr(ctl_ff.idx),
		.rdata(buf_rdata)
	);

	// Outputs straight from the state register
	assign status_byte = ctl_ff.status;
	assign netboot_start = ctl_ff.netboot_start;
	assign mem_req = ctl_ff.mem_req;
	assign mem_we = ctl_ff.mem_we;
	assign mem_addr = ctl_ff.mem_addr;
	assign mem_wdata = ctl_ff.mem_wdata;
	assign status_led = ctl_ff.led;
	assign selftest_run = ctl_ff.selftest_run;
	assign cfg_done = ctl_ff.cfg_done;
	assign cfg_code = ctl_ff.code;

endmodule // hrc_ctrl

`default_nettype wire

// [rtl/hrc_pkg.sv]
// Package: constants and types for the host reset/configuration handshake block
package hrc_pkg;

	// Clock and timing
	localparam int unsigned CLK_HZ = 10_000_000; // Core clock rate
	localparam int unsigned SELFTEST_TO_S = 3; // Self-test budget, seconds
	localparam int unsigned CFG_TO_S = 3; // Fetch budget after last byte, seconds
	localparam int unsigned BLINK_MS = 250; // Indicator step, milliseconds
	localparam int unsigned SELFTEST_TO_CYC = SELFTEST_TO_S * CLK_HZ;
	localparam int unsigned CFG_TO_CYC = CFG_TO_S * CLK_HZ;
	localparam int unsigned BLINK_CYC = (BLINK_MS * (CLK_HZ / 1000));

	// Status byte bit positions
	localparam int unsigned ST_PASS_BIT = 0; // Self-test passed
	localparam int unsigned ST_READY_BIT = 3; // Command byte not yet consumed
	localparam int unsigned ST_LOOP_BIT = 6; // Loopback test failed

	// Address hand-over sequence
	localparam int unsigned SEQ_LEN = 8; // Bytes per sequence
	localparam logic [2:0] SEQ_PFX_LAST = 3'h3; // Index of last prefix byte
	localparam logic [2:0] SEQ_LAST = 3'h7; // Index of last address byte
	localparam logic [31:0] SEQ_PREFIX = 32'h0000_FFFF; // FF,FF,00,00 from byte 0

	// Configuration message layout (byte offsets)
	localparam int unsigned MSG_LEN = 80; // Bytes fetched and checked
	localparam int unsigned BUF_AW = 7; // Buffer address width
	localparam logic [6:0] OFF_RSV0 = 7'h00; // Two-byte reserved word
	localparam logic [6:0] OFF_VER = 7'h02; // Four ASCII version digits
	localparam logic [6:0] OFF_CODE = 7'h06; // Completion code
	localparam logic [6:0] OFF_MODE = 7'h07; // Operation mode
	localparam logic [6:0] OFF_FMT = 7'h08; // Data format option, two bytes
	localparam logic [6:0] OFF_CTX = 7'h0A; // Context, three bytes
	localparam logic [6:0] OFF_CTX_MID = 7'h0B; // Context value in reply
	localparam logic [6:0] OFF_AMODE = 7'h0D; // Address mode
	localparam logic [6:0] OFF_RSV14 = 7'h0E; // Reserved byte
	localparam logic [6:0] OFF_MAPSZ = 7'h0F; // Memory map size
	localparam logic [6:0] OFF_TP = 7'h10; // Test pattern bytes
	localparam logic [6:0] OFF_TP_RSV = 7'h1C; // Zero tail of test pattern
	localparam logic [6:0] OFF_MOVE = 7'h30; // Movable block address, four bytes
	localparam logic [6:0] OFF_NPROC = 7'h34;
	localparam logic [6:0] OFF_NMBOX = 7'h35;
	localparam logic [6:0] OFF_NSLOT = 7'h36;
	localparam logic [6:0] OFF_NHOST = 7'h37;
	localparam logic [6:0] OFF_H2D_IRQ = 7'h3E; // Queue interrupt types
	localparam logic [6:0] OFF_D2H_IRQ = 7'h4A;
	localparam logic [31:0] TP_BYTES = 32'h0F07_0301; // 01,03,07,0F from byte 0

	// Field limits
	localparam logic [7:0] RSV0_VAL = 8'h01;
	localparam logic [7:0] MODE_LINK = 8'h00;
	localparam logic [7:0] MODE_NET = 8'h02;
	localparam logic [7:0] FMT_RSV_MASK = 8'hFE;
	localparam logic [7:0] AMODE_RSV_MASK = 8'hFC;
	localparam logic [7:0] KEEP_VAL = 8'hFF; // Keep current value
	localparam logic [7:0] CNT_MAX = 8'h80; // Processes and mailboxes
	localparam logic [7:0] SLOT_MAX = 8'hFC;
	localparam logic [7:0] HOST_MAX = 8'h08;
	localparam logic [7:0] IRQ_TYPE_MAX = 8'h03;

	// Completion codes
	localparam logic [7:0] CC_OK = 8'h00;
	localparam logic [7:0] CC_PEND = 8'hFF;
	localparam logic [7:0] CC_MODE = 8'hA4;
	localparam logic [7:0] CC_PATTERN = 8'hA5;
	localparam logic [7:0] CC_FORMAT = 8'hA7;
	localparam logic [7:0] CC_MOVE = 8'hA8;
	localparam logic [7:0] CC_NPROC = 8'hA9;
	localparam logic [7:0] CC_NMBOX = 8'hAA;
	localparam logic [7:0] CC_NSLOT = 8'hAB;
	localparam logic [7:0] CC_NHOST = 8'hAC;
	localparam logic [7:0] CC_QUEUE = 8'hAD;
	localparam logic [7:0] CC_NOMEM = 8'hAE;
	localparam logic [7:0] CC_NETBOOT = 8'hAF;
	localparam logic [7:0] CC_SELFTEST = 8'h01; // Self-test failure indication
	localparam logic [2:0] REPLY_LAST = 3'h5; // Reply steps 0..5

	// Controller states, one-hot
	typedef enum logic [7:0] {
		S_SELFTEST = 8'h01,
		S_NETBOOT = 8'h02,
		S_WAIT = 8'h04,
		S_FETCH = 8'h08,
		S_CHECK = 8'h10,
		S_REPLY = 8'h20,
		S_RUN = 8'h40,
		S_ERR = 8'h80
	} hrc_state_e;

endpackage

// [rtl/hrc_msg_buf.sv]
// Small byte memory holding the fetched configuration message
`timescale 1ns/1ps
`default_nettype none

module hrc_msg_buf (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Write side
	input wire logic we,
	input wire logic [hrc_pkg::BUF_AW-1:0] waddr,
	input wire logic [7:0] wdata,
	// Read side, data one cycle after the address
	input wire logic [hrc_pkg::BUF_AW-1:0] raddr,
	output logic [7:0] rdata
);
	import hrc_pkg::*;

	// Whole buffer state in one record
	typedef struct packed {
		logic [(1<<BUF_AW)-1:0][7:0] mem; // Message bytes
		logic [7:0] rdata; // Registered read data
	} hrc_buf_s;

	hrc_buf_s buf_ff; // Registered state
	hrc_buf_s nxt_buf; // Next state

	// Read first: registered read of the old contents, then write
	always_comb begin
		nxt_buf = buf_ff;
		nxt_buf.rdata = buf_ff.mem[raddr];
		if (we) begin
			nxt_buf.mem[waddr] = wdata;
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			buf_ff <= '0;
		end else begin
			buf_ff <= nxt_buf;
		end
	end

	assign rdata = buf_ff.rdata;

endmodule // hrc_msg_buf

`default_nettype wire

// [testbench/hrc_ctrl_asserts.sv]
// Port checker for the handshake controller
`timescale 1ns/1ps
`default_nettype none
module hrc_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Host side
	input wire logic bus_init,
	input wire logic rst_port_wr,
	input wire logic cmd_wr,
	input wire logic [7:0] status_byte,
	input wire logic selftest_done,
	input wire logic selftest_pass,
	input wire logic loop_fail,
	// Memory side
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic mem_ack,
	// Progress
	input wire logic status_led,
	input wire logic selftest_run,
	input wire logic cfg_done,
	input wire logic [7:0] cfg_code
);
	wire logic soft_rst = bus_init | rst_port_wr; // Either in-band reset
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	reset_vals_a: assert property (soft_rst |=> status_byte == 8'h00 && cfg_code == 8'hFF)
		else $error("reset left old state");
	lit_test_a: assert property (selftest_run |-> status_led)
		else $error("indicator dark in self test");
	pass_cause_a: assert property ($rose(status_byte[0]) |-> $past(selftest_done) && $past(selftest_pass))
		else $error("pass bit without a pass");
	pass_hold_a: assert property (status_byte[0] && !soft_rst |=> status_byte[0])
		else $error("pass bit dropped");
	ready_rise_a: assert property (cmd_wr && !status_byte[3] && !soft_rst |-> ##[1:2] status_byte[3])
		else $error("byte not flagged busy");
	ready_one_a: assert property (status_byte[3] && !soft_rst |=> !status_byte[3])
		else $error("busy flag stuck");
	loop_copy_a: assert property (!$past(soft_rst) |-> status_byte[6] == $past(loop_fail))
		else $error("loop bit not copied");
	req_hold_a: assert property (mem_req && !mem_ack && !soft_rst |=> mem_req && $stable(mem_addr) && $stable(mem_we))
		else $error("request moved before answer");
	code_final_a: assert property (cfg_done |-> cfg_code == 8'h00)
		else $error("done with nonzero code");
	wr_not_pend_a: assert property (mem_req && mem_we |-> mem_wdata != 8'hFF)
		else $error("pending code written");
	cover property (cfg_done);
	cover property (cfg_code == 8'hA4);
	cover property (cmd_wr && status_byte[3]);
endmodule // hrc_chk
bind hrc_ctrl hrc_chk u_chk (.clk(clk), .rst_n(rst_n), .bus_init(bus_init),
	.rst_port_wr(rst_port_wr), .cmd_wr(cmd_wr), .status_byte(status_byte),
	.selftest_done(selftest_done), .selftest_pass(selftest_pass), .loop_fail(loop_fail),
	.mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
	.mem_ack(mem_ack), .status_led(status_led), .selftest_run(selftest_run),
	.cfg_done(cfg_done), .cfg_code(cfg_code));
`default_nettype wire

// [testbench/hrc_host.sv]
// Host memory model serving the controller's shared-memory port
`timescale 1ns/1ps
`default_nettype none
module hrc_host #(
	parameter logic [31:0] BASE = 32'h0 // Message image address
) (
	// Clock
	input wire logic clk,
	// Request
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	// Answer
	output logic mem_ack,
	output logic mem_err,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [80]; // Message image, loaded by the bench
	logic [1:0] wait_q = 2'h0; // Stall cycles left
	logic slow_q = 1'b0; // Every other access is slow
	wire logic [6:0] idx = 7'(mem_addr - BASE);
	initial begin
		mem_ack = 1'b0;
		mem_err = 1'b0; // No bus errors raised
		mem_rdata = 8'h00;
	end
	// Data lines churn when idle so stale bytes never look valid
	always @(posedge clk) begin
		if (mem_ack || !mem_req) begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
		end else if (wait_q != 2'h0) begin
			wait_q <= wait_q - 2'h1;
			mem_rdata <= ~mem_rdata;
		end else begin
			mem_ack <= 1'b1;
			wait_q <= {slow_q, 1'b0};
			slow_q <= ~slow_q;
			if (mem_we)
				mem[idx] <= mem_wdata; // Code polled here
			else
				mem_rdata <= mem[idx];
		end
	end
endmodule // hrc_host
`default_nettype wire

// [testbench/testbench.sv]
// Bench: reset, self test, address hand-over and reply codes
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import hrc_pkg::*;
	localparam logic [31:0] BASE = 32'h0004_1C20; // Even address
	localparam logic [31:0] VER = "1010"; // Default version digits
	logic clk, rst_n, bus_init, rst_port_wr, cmd_wr, selftest_done, selftest_pass;
	logic loop_fail, board_mem_low, netboot_start, netboot_done, netboot_ok;
	logic mem_req, mem_we, mem_ack, mem_err, status_led, selftest_run, cfg_done;
	logic strap_netboot;
	logic led_q; // Indicator level before a blink step
	int n_lit; // Lit cycles over one error-code period
	logic [7:0] cmd_wdata, status_byte, mem_wdata, mem_rdata, cfg_code;
	logic [31:0] mem_addr;
	int n_errors = 0;
	int check_count = 0;
	// Cases: patched offset, value, expected code
	logic [6:0] t_off [12] = '{7'h0E, 7'h07, 7'h07, 7'h07, 7'h00, 7'h10,
		7'h34, 7'h35, 7'h36, 7'h37, 7'h3E, 7'h0E};
	logic [7:0] t_val [12] = '{8'h00, 8'h00, 8'h05, 8'h02, 8'h02, 8'h00,
		8'h00, 8'h81, 8'hFD, 8'h09, 8'h04, 8'h00};
	logic [7:0] t_exp [12] = '{CC_OK, CC_OK, CC_MODE, CC_NETBOOT, CC_FORMAT, CC_PATTERN,
		CC_NPROC, CC_NMBOX, CC_NSLOT, CC_NHOST, CC_QUEUE, CC_NOMEM};
	wire logic [31:0] got_ver = {u_host.mem[2], u_host.mem[3], u_host.mem[4], u_host.mem[5]};
	hrc_ctrl #(.SELFTEST_TO(200), .CFG_TO(2000), .BLINK(4)) DUT (
		.clk, .rst_n, .bus_init, .rst_port_wr, .cmd_wr, .cmd_wdata, .status_byte,
		.strap_netboot, .selftest_done, .selftest_pass, .loop_fail, .board_mem_low,
		.netboot_start, .netboot_done, .netboot_ok, .mem_req, .mem_we, .mem_addr,
		.mem_wdata, .mem_ack, .mem_err, .mem_rdata, .status_led, .selftest_run,
		.cfg_done, .cfg_code);
	hrc_host #(.BASE(BASE)) u_host (.clk, .mem_req, .mem_we, .mem_addr, .mem_wdata,
		.mem_ack, .mem_err, .mem_rdata);
	// Boot engine stand-in: ends at once, outcome from netboot_ok
	always @(posedge clk) netboot_done <= netboot_start;
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask
	// Reset by rst_n, bus init or port write; optional passing self test
	task automatic boot(input int how, input bit pass);
		rst_n = (how != 0);
		bus_init = (how == 1);
		rst_port_wr = (how == 2);
		tick(how == 2 ? 1 : 6);
		rst_n = 1;
		bus_init = 0;
		rst_port_wr = 0;
		tick(1);
		chk("status", status_byte, 8'h00);
		chk("code", cfg_code, CC_PEND);
		chk("lit", {selftest_run, status_led}, 2'b11);
		if (pass) begin
			tick(4);
			selftest_done = 1;
			selftest_pass = 1;
			tick(1);
			selftest_done = 0;
			tick(1);
			chk("pass", status_byte[0], 1'b1);
		end
	endtask
	// One command byte; twice keeps the strobe up into the busy cycle
	task automatic put(input logic [7:0] b, input bit twice);
		for (int k = 0; k < 40 && status_byte[3] !== 1'b0; k++) tick(1);
		if (status_byte[3] !== 1'b0)
			n_errors++;
		cmd_wdata = b;
		cmd_wr = 1;
		tick(1);
		if (twice) begin
			cmd_wdata = 8'h5A; // Must be dropped
			tick(1);
		end
		cmd_wr = 0;
		tick(1);
	endtask
	task automatic seq(input logic [31:0] a);
		put(8'hFF, 0);
		put(8'h00, 0); // Broken prefix, discarded
		put(8'hFF, 0);
		put(8'hFF, 1);
		put(8'h00, 0);
		put(8'h00, 0);
		for (int i = 0; i < 4; i++) put(a[8*i +: 8], 0);
	endtask
	// Valid request image, then one field patched
	task automatic load(input int c);
		for (int i = 0; i < 80; i++) u_host.mem[i] = 8'h00;
		u_host.mem[0] = RSV0_VAL;
		u_host.mem[6] = CC_PEND;
		u_host.mem[7] = 8'h01;
		{u_host.mem[19], u_host.mem[18], u_host.mem[17], u_host.mem[16]} = TP_BYTES;
		for (int i = 48; i < 56; i++) u_host.mem[i] = KEEP_VAL;
		u_host.mem[t_off[c]] = t_val[c];
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	// Watchdog well beyond the expected run
	initial begin
		repeat (60000) @(posedge clk);
		n_errors++;
		close_out();
	end
	initial begin
		{cmd_wr, selftest_done, selftest_pass, loop_fail, board_mem_low} = '0;
		{strap_netboot, netboot_ok, cmd_wdata, bus_init, rst_port_wr} = '0;
		rst_n = 0;
		for (int c = 0; c < 12; c++) begin
			boot(c % 3, 1);
			load(c);
			board_mem_low = (t_exp[c] == CC_NOMEM);
			loop_fail = c[0];
			seq(BASE);
			for (int k = 0; k < 5000 && u_host.mem[6] === CC_PEND; k++) tick(1);
			tick(4);
			chk("reply", u_host.mem[6], t_exp[c]);
			chk("cfg_code", cfg_code, t_exp[c]);
			chk("ver", got_ver, t_exp[c] == CC_OK ? VER : 32'h0);
			chk("done", cfg_done, t_exp[c] == CC_OK);
			loop_fail = 0;
			board_mem_low = 0;
			tick(2);
		end
		// Strap boot that succeeds, then the indicator blinks
		strap_netboot = 1;
		netboot_ok = 1;
		boot(0, 1);
		tick(4);
		chk("strap", {cfg_done, cfg_code}, {1'b1, CC_OK});
		led_q = status_led;
		tick(4);
		chk("blink", status_led, !led_q);
		strap_netboot = 0;
		netboot_ok = 0;
		boot(1, 1);
		load(0);
		seq(BASE | 32'h1); // Odd address: no fetch
		tick(1000);
		chk("odd", {mem_req, u_host.mem[6], cfg_code}, {1'b0, CC_PEND, CC_FORMAT});
		boot(2, 0);
		tick(300);
		chk("fail", {selftest_run, status_byte[0], cfg_code}, {2'b00, CC_SELFTEST});
		// One full code period: one set bit lit for one step
		n_lit = 0;
		repeat (64) begin
			tick(1);
			n_lit += status_led;
		end
		chk("err_led", n_lit, 4 * $countones(CC_SELFTEST));
		close_out();
	end
endmodule // testbench
`default_nettype wire
